// file: irqc_pkg.sv
// constants shared by the interrupt priority and source block
package irqc_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 8;
	localparam int PC_W    = 21;
	localparam int SP_W    = 4;
	localparam int VEC_W   = 16;

	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_PRIO_ONE   = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_PRIO_TWO   = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_PRIO_THREE = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_RST_CAUSE  = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_CTL_FIRST  = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_CTL_SECOND = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_CTL_THIRD  = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_TMR0_LOW   = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_TMR0_HIGH  = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_TMR0_CFG   = 4'h9;

	// ==========================================================
	// reset values and implemented / writable masks
	localparam logic [DATA_W-1:0] PRIO_ONE_MASK   = 8'hfb;
	localparam logic [DATA_W-1:0] PRIO_TWO_MASK   = 8'hce;
	localparam logic [DATA_W-1:0] PRIO_THREE_MASK = 8'h36;
	localparam logic [DATA_W-1:0] PRIO_THREE_WR   = 8'h06;
	localparam logic [DATA_W-1:0] RST_CAUSE_RST   = 8'h3c;
	localparam logic [DATA_W-1:0] RST_CAUSE_MASK  = 8'hbf;
	localparam logic [DATA_W-1:0] RST_CAUSE_WR    = 8'hb3;
	localparam logic [DATA_W-1:0] CTL_FIRST_RST   = 8'h00;
	localparam logic [DATA_W-1:0] CTL_SECOND_RST  = 8'h7f;
	localparam logic [DATA_W-1:0] CTL_SECOND_MASK = 8'h7f;
	localparam logic [DATA_W-1:0] CTL_THIRD_RST   = 8'hc0;
	localparam logic [DATA_W-1:0] BYTE_ZERO       = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_FULL       = 8'hff;

	// ==========================================================
	// field positions
	localparam int RC_PRIO_EN   = 7;
	localparam int C1_GIE_HIGH  = 7;
	localparam int C1_GIE_LOW   = 6;
	localparam int C1_T0_EN     = 5;
	localparam int C1_X0_EN     = 4;
	localparam int C1_PB_EN     = 3;
	localparam int C1_T0_FLAG   = 2;
	localparam int C1_X0_FLAG   = 1;
	localparam int C1_PB_FLAG   = 0;
	localparam int C2_EDGE_LSB  = 3;
	localparam int C2_T0_PRIO   = 2;
	localparam int C2_X3_PRIO   = 1;
	localparam int C2_PB_PRIO   = 0;
	localparam int C3_X2_PRIO   = 7;
	localparam int C3_X1_PRIO   = 6;
	localparam int C3_EN_LSB    = 3;
	localparam int C3_FLAG_LSB  = 0;
	localparam int CFG_SIXTEEN  = 0;

	// ==========================================================
	// vectors and service state
	localparam logic [VEC_W-1:0] VEC_HIGH = 16'h0008;
	localparam logic [VEC_W-1:0] VEC_LOW  = 16'h0018;

	typedef enum logic [1:0] {SRV_IDLE, SRV_LOW, SRV_HIGH, SRV_NESTED} irqc_srv_t;

endpackage

// file: irqc_stack_mem.sv
// return address stack storage with registered read data
`timescale 1ns/1ps
module irqc_stack_mem
	import irqc_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            wr_en,
	input  wire logic [SP_W-1:0] wr_addr,
	input  wire logic [PC_W-1:0] wr_data,
	input  wire logic            rd_en,
	input  wire logic [SP_W-1:0] rd_addr,
	output logic      [PC_W-1:0] rd_data_q
);

	// ==========================================================
	// storage
	logic [PC_W-1:0] mem_q [2**SP_W];

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// read data hold until the next pop
	always_ff @(posedge clk)
	begin
		if (rd_en)
		begin
			rd_data_q <= mem_q[rd_addr];
		end
	end

endmodule

// file: irqc_core.sv
// interrupt priority, source flags and context save
`timescale 1ns/1ps

// Summary of operation
// - a priority bit at 1 makes its source high priority, at 0 low
// - priority bits reset to 1; second serial port rx/tx priority read-only
// - unimplemented bits of priority and reset control registers read zero
// - reset control bit 7 enables two priority levels; resets to 0
// - reset control bits 5..0 are set by each reset or wake cause and held
// - each external pin edge select picks rising when set, falling when clear
// - the selected edge on an external pin sets its flag
// - an external pin with its enable clear requests nothing
// - external pin wakes from sleep if its enable was set beforehand
// - after wake the core vectors only if the global enable is set
// - external pins one to three take priority from their dedicated bits
// - external pin zero is always a high priority source
// - timer zero flag sets on wrap, ff to 00 or ffff to 0000
// - timer zero enable at first control bit 5, priority second control bit 2
// - a change on port b pins 7..4 sets the change flag
// - port change enable first control bit 3, priority second control bit 0
// - taking an interrupt pushes the return address on the call stack
// - taking an interrupt copies working, status and bank to the shadow
// - peripheral priority bits act only with priority levels enabled
// - in single level mode peripherals also need the peripheral enable
module irqc_core
	import irqc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata_q,
	input  wire logic [3:0]        ext_pins,
	input  wire logic [3:0]        port_b_upper,
	input  wire logic              timer_zero_tick,
	input  wire logic [DATA_W-1:0] periph_pend_one,
	input  wire logic [DATA_W-1:0] periph_pend_two,
	input  wire logic [DATA_W-1:0] periph_pend_three,
	input  wire logic [5:0]        reset_cause_evt,
	input  wire logic              sleep_mode,
	input  wire logic              core_irq_ack,
	input  wire logic              core_retfie,
	input  wire logic [PC_W-1:0]   core_pc,
	input  wire logic [DATA_W-1:0] core_working,
	input  wire logic [DATA_W-1:0] core_status,
	input  wire logic [DATA_W-1:0] core_bank,
	output logic                   irq_req_q,
	output logic                   irq_high_q,
	output logic      [VEC_W-1:0]  irq_vector_q,
	output logic                   wake_q,
	output logic      [PC_W-1:0]   ret_pc_q,
	output logic      [DATA_W-1:0] shadow_working_q,
	output logic      [DATA_W-1:0] shadow_status_q,
	output logic      [DATA_W-1:0] shadow_bank_q
);

	// ==========================================================
	// helpers
	function automatic logic [3:0] edge_seen(input logic [3:0] prev, input logic [3:0] cur,
		input logic [3:0] rising);
		edge_seen = (rising & ~prev & cur) | (~rising & prev & ~cur);
	endfunction

	function automatic logic [DATA_W-1:0] masked(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [DATA_W-1:0] wmask);
		masked = (old_v & ~wmask) | (new_v & wmask);
	endfunction

	// ==========================================================
	// state
	logic [DATA_W-1:0] prio_one_q, prio_two_q, prio_three_q, rst_cause_q;
	logic [DATA_W-1:0] ctl_first_q, ctl_second_q, ctl_third_q;
	logic [DATA_W-1:0] tmr_lo_q, tmr_hi_q, tmr_cfg_q, rd_mux;
	logic [3:0]        ext_prev_q, ext_edge, wake_mask_q;
	logic [3:0]        pb_prev_q;
	logic              sleep_prev_q, pb_change, tmr_wrap;
	logic [SP_W-1:0]   sp_q;
	irqc_srv_t         srv_q;

	wire logic wr_hit_ctl1 = reg_wr && (reg_addr == OFF_CTL_FIRST);
	wire logic wr_hit_ctl3 = reg_wr && (reg_addr == OFF_CTL_THIRD);
	wire logic prio_en     = rst_cause_q[RC_PRIO_EN];

	// ==========================================================
	// priority registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prio_one_q   <= PRIO_ONE_MASK;
			prio_two_q   <= PRIO_TWO_MASK;
			prio_three_q <= PRIO_THREE_MASK;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				OFF_PRIO_ONE:   prio_one_q   <= reg_wdata & PRIO_ONE_MASK;
				OFF_PRIO_TWO:   prio_two_q   <= reg_wdata & PRIO_TWO_MASK;
				OFF_PRIO_THREE: prio_three_q <= masked(prio_three_q, reg_wdata, PRIO_THREE_WR);
				default:        ;
			endcase
		end
	end

	// ==========================================================
	// reset cause and priority enable
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rst_cause_q <= RST_CAUSE_RST;
		end
		else
		begin
			// a cause event wins over a software clear in the same cycle
			if (reg_wr && reg_addr == OFF_RST_CAUSE)
			begin
				rst_cause_q <= masked(rst_cause_q, reg_wdata, RST_CAUSE_WR)
					| {2'b00, reset_cause_evt};
			end
			else
			begin
				rst_cause_q <= rst_cause_q | {2'b00, reset_cause_evt};
			end
		end
	end

	// ==========================================================
	// edge, change and wrap detection
	assign ext_edge  = edge_seen(ext_prev_q, ext_pins,
		ctl_second_q[C2_EDGE_LSB +: 4]);
	assign pb_change = |(pb_prev_q ^ port_b_upper);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			// follow the pins through reset so a pin held high gives no false edge
			ext_prev_q <= ext_pins;
			pb_prev_q  <= port_b_upper;
		end
		else
		begin
			ext_prev_q <= ext_pins;
			pb_prev_q  <= port_b_upper;
		end
	end

	// 16-bit mode counts the pair; 8-bit leaves the high byte alone
	assign tmr_wrap = timer_zero_tick && (tmr_lo_q == BYTE_FULL)
		&& (!tmr_cfg_q[CFG_SIXTEEN] || tmr_hi_q == BYTE_FULL);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tmr_lo_q  <= BYTE_ZERO;
			tmr_hi_q  <= BYTE_ZERO;
			tmr_cfg_q <= BYTE_ZERO;
		end
		else
		begin
			if (reg_wr && reg_addr == OFF_TMR0_LOW)
				tmr_lo_q <= reg_wdata;
			else if (timer_zero_tick)
				tmr_lo_q <= tmr_lo_q + 8'h01;
			if (reg_wr && reg_addr == OFF_TMR0_HIGH)
				tmr_hi_q <= reg_wdata;
			else if (timer_zero_tick && tmr_cfg_q[CFG_SIXTEEN] && tmr_lo_q == BYTE_FULL)
				tmr_hi_q <= tmr_hi_q + 8'h01;
			if (reg_wr && reg_addr == OFF_TMR0_CFG)
				tmr_cfg_q <= {7'h00, reg_wdata[CFG_SIXTEEN]};
		end
	end

	// ==========================================================
	// source qualification
	wire logic src_t0 = ctl_first_q[C1_T0_FLAG] & ctl_first_q[C1_T0_EN];
	wire logic src_x0 = ctl_first_q[C1_X0_FLAG] & ctl_first_q[C1_X0_EN];
	wire logic src_pb = ctl_first_q[C1_PB_FLAG] & ctl_first_q[C1_PB_EN];
	wire logic [2:0] src_x = ctl_third_q[C3_FLAG_LSB +: 3]
		& ctl_third_q[C3_EN_LSB +: 3];
	wire logic [2:0] x_prio = {ctl_second_q[C2_X3_PRIO], ctl_third_q[C3_X2_PRIO],
		ctl_third_q[C3_X1_PRIO]};

	wire logic core_hi = src_x0
		| (src_t0 & ctl_second_q[C2_T0_PRIO])
		| (src_pb & ctl_second_q[C2_PB_PRIO])
		| (|(src_x & x_prio));
	wire logic core_lo = (src_t0 & ~ctl_second_q[C2_T0_PRIO])
		| (src_pb & ~ctl_second_q[C2_PB_PRIO])
		| (|(src_x & ~x_prio));
	wire logic per_hi = |(periph_pend_one & prio_one_q) | |(periph_pend_two & prio_two_q)
		| |(periph_pend_three & prio_three_q);
	wire logic per_lo = |(periph_pend_one & ~prio_one_q & PRIO_ONE_MASK)
		| |(periph_pend_two & ~prio_two_q & PRIO_TWO_MASK)
		| |(periph_pend_three & ~prio_three_q & PRIO_THREE_MASK);
	wire logic per_any = |periph_pend_one | |periph_pend_two | |periph_pend_three;

	wire logic gie_high = ctl_first_q[C1_GIE_HIGH];
	wire logic gie_low  = ctl_first_q[C1_GIE_LOW];

	// single level: bit 6 is the peripheral enable, everything goes high
	wire logic want_legacy = gie_high & (src_t0 | src_x0 | src_pb | (|src_x)
		| (gie_low & per_any));
	wire logic want_high = prio_en ? gie_high & (core_hi | per_hi) : want_legacy;
	wire logic want_low  = prio_en & gie_high & gie_low & (core_lo | per_lo);
	wire logic take      = core_irq_ack & irq_req_q;

	// ==========================================================
	// first control register: enables, flags, global enables
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctl_first_q <= CTL_FIRST_RST;
		end
		else
		begin
			logic [DATA_W-1:0] v;
			v = wr_hit_ctl1 ? reg_wdata : ctl_first_q;
			// hardware sets win over a software clear in the same cycle
			v[C1_T0_FLAG] = v[C1_T0_FLAG] | tmr_wrap;
			v[C1_X0_FLAG] = v[C1_X0_FLAG] | ext_edge[0];
			v[C1_PB_FLAG] = v[C1_PB_FLAG] | pb_change;
			if (take)
			begin
				if (!prio_en || irq_high_q)
					v[C1_GIE_HIGH] = 1'b0;
				else
					v[C1_GIE_LOW] = 1'b0;
			end
			else if (core_retfie)
			begin
				if (!prio_en || srv_q == SRV_HIGH || srv_q == SRV_NESTED)
					v[C1_GIE_HIGH] = 1'b1;
				else
					v[C1_GIE_LOW] = 1'b1;
			end
			ctl_first_q <= v;
		end
	end

	// ==========================================================
	// second and third control registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctl_second_q <= CTL_SECOND_RST;
		end
		else if (reg_wr && reg_addr == OFF_CTL_SECOND)
		begin
			ctl_second_q <= reg_wdata & CTL_SECOND_MASK;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctl_third_q <= CTL_THIRD_RST;
		end
		else
		begin
			logic [DATA_W-1:0] v;
			v = wr_hit_ctl3 ? reg_wdata : ctl_third_q;
			v[C3_FLAG_LSB +: 3] = v[C3_FLAG_LSB +: 3] | ext_edge[3:1];
			ctl_third_q <= v;
		end
	end

	// ==========================================================
	// request, vector and service tracking
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			irq_req_q    <= 1'b0;
			irq_high_q   <= 1'b0;
			irq_vector_q <= VEC_HIGH;
		end
		else
		begin
			// dropped for a cycle after a take so the cleared enable is seen
			irq_req_q    <= (want_high || want_low) && !take;
			irq_high_q   <= want_high;
			irq_vector_q <= want_high ? VEC_HIGH : VEC_LOW;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			srv_q <= SRV_IDLE;
		end
		else
		begin
			case (srv_q)
				SRV_IDLE:
					if (take)
						srv_q <= irq_high_q ? SRV_HIGH : SRV_LOW;
				SRV_LOW:
					if (take && irq_high_q)
						srv_q <= SRV_NESTED;
					else if (core_retfie)
						srv_q <= SRV_IDLE;
				SRV_HIGH:
					if (core_retfie)
						srv_q <= SRV_IDLE;
				SRV_NESTED:
					if (core_retfie)
						srv_q <= SRV_LOW;
				default:
					srv_q <= SRV_IDLE;
			endcase
		end
	end

	// ==========================================================
	// context save
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			shadow_working_q <= BYTE_ZERO;
			shadow_status_q  <= BYTE_ZERO;
			shadow_bank_q    <= BYTE_ZERO;
		end
		else if (take)
		begin
			shadow_working_q <= core_working;
			shadow_status_q  <= core_status;
			shadow_bank_q    <= core_bank;
		end
	end

	// overflow past the stack depth wraps silently
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			sp_q <= '0;
		else if (take)
			sp_q <= sp_q + 4'h1;
		else if (core_retfie)
			sp_q <= sp_q - 4'h1;
	end

	irqc_stack_mem u_stack (
		.clk       (clk),
		.wr_en     (take),
		.wr_addr   (sp_q),
		.wr_data   (core_pc),
		.rd_en     (core_retfie && !take),
		.rd_addr   (sp_q - 4'h1),
		.rd_data_q (ret_pc_q)
	);

	// ==========================================================
	// sleep wake
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sleep_prev_q <= 1'b0;
			wake_mask_q  <= 4'h0;
			wake_q       <= 1'b0;
		end
		else
		begin
			sleep_prev_q <= sleep_mode;
			// enables are frozen at entry; later enables do not wake
			if (sleep_mode && !sleep_prev_q)
				wake_mask_q <= {ctl_third_q[C3_EN_LSB +: 3], ctl_first_q[C1_X0_EN]};
			wake_q <= sleep_mode && sleep_prev_q && |(wake_mask_q
				& {ctl_third_q[C3_FLAG_LSB +: 3], ctl_first_q[C1_X0_FLAG]});
		end
	end

	// ==========================================================
	// register read
	always_comb
	begin
		case (reg_addr)
			OFF_PRIO_ONE:   rd_mux = prio_one_q;
			OFF_PRIO_TWO:   rd_mux = prio_two_q;
			OFF_PRIO_THREE: rd_mux = prio_three_q;
			OFF_RST_CAUSE:  rd_mux = rst_cause_q & RST_CAUSE_MASK;
			OFF_CTL_FIRST:  rd_mux = ctl_first_q;
			OFF_CTL_SECOND: rd_mux = ctl_second_q;
			OFF_CTL_THIRD:  rd_mux = ctl_third_q;
			OFF_TMR0_LOW:   rd_mux = tmr_lo_q;
			OFF_TMR0_HIGH:  rd_mux = tmr_hi_q;
			OFF_TMR0_CFG:   rd_mux = tmr_cfg_q;
			default:        rd_mux = BYTE_ZERO;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			reg_rdata_q <= BYTE_ZERO;
		else
			reg_rdata_q <= reg_rd ? rd_mux : BYTE_ZERO;
	end

endmodule

// file: irqc_core_sva.sv
// checker for the interrupt priority and source block ports
`timescale 1ns/1ps
module irqc_core_sva
	import irqc_pkg::*;
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata_q,
	input wire logic              sleep_mode,
	input wire logic              core_irq_ack,
	input wire logic              core_retfie,
	input wire logic [DATA_W-1:0] core_working,
	input wire logic [DATA_W-1:0] core_status,
	input wire logic [DATA_W-1:0] core_bank,
	input wire logic              irq_req_q,
	input wire logic              irq_high_q,
	input wire logic [VEC_W-1:0]  irq_vector_q,
	input wire logic              wake_q,
	input wire logic [DATA_W-1:0] shadow_working_q,
	input wire logic [DATA_W-1:0] shadow_status_q,
	input wire logic [DATA_W-1:0] shadow_bank_q
);
	// ==========================================================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_rdata_slot: assert property (reg_rdata_q != BYTE_ZERO |-> $past(reg_rd))
		else $error("read data outside its slot");
	chk_unimpl_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFF_PRIO_THREE
		|-> (reg_rdata_q & ~PRIO_THREE_MASK) == BYTE_ZERO)
		else $error("unimplemented priority bit read as one");
	chk_reset_quiet: assert property ($past(sys_rst) |-> !irq_req_q && !wake_q
		&& irq_vector_q == VEC_HIGH)
		else $error("outputs not quiet after reset");
	chk_shadow_copy: assert property (core_irq_ack && irq_req_q |=>
		shadow_working_q == $past(core_working) && shadow_status_q == $past(core_status)
		&& shadow_bank_q == $past(core_bank))
		else $error("context not copied on take");
	chk_high_take: assert property (core_irq_ack && irq_req_q && irq_high_q |=> !irq_req_q)
		else $error("request stays up after high take");
	chk_vector_high: assert property (irq_req_q && irq_high_q |-> irq_vector_q == VEC_HIGH)
		else $error("high request on wrong vector");
	chk_global_off: assert property ((reg_wr && reg_addr == OFF_CTL_FIRST
		&& reg_wdata[7:6] == 2'b00 && !core_retfie) ##1 !core_retfie |=> !irq_req_q)
		else $error("request with global enables clear");
	chk_wake_awake: assert property (!sleep_mode && !$past(sleep_mode) |-> !wake_q)
		else $error("wake raised while awake");

	// ==========================================================
	// scenarios reached
	cover property (core_irq_ack && irq_req_q && !irq_high_q);
	cover property (irq_req_q && irq_vector_q == VEC_LOW);
	cover property (wake_q && sleep_mode);
endmodule

bind irqc_core irqc_core_sva i_irqc_core_sva (.*);

// file: irqc_cpu_model.sv
// processor core stand-in that takes requests after a set delay
`timescale 1ns/1ps
module irqc_cpu_model
	import irqc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              irq_req_q,
	input  wire logic              auto_en,
	input  wire logic [3:0]        ack_delay,
	output logic                   core_irq_ack,
	output logic      [7:0]        takes_q,
	output logic      [PC_W-1:0]   core_pc,
	output logic      [DATA_W-1:0] core_working,
	output logic      [DATA_W-1:0] core_status,
	output logic      [DATA_W-1:0] core_bank
);
	// ==========================================================
	// context differs on every take so a stale copy shows
	logic [3:0]  wait_q;
	logic [23:0] ctx_q;
	assign core_pc      = 21'h000100 + {13'h0000, takes_q};
	assign core_working = 8'ha0 + takes_q;
	assign core_status  = 8'h50 + takes_q;
	assign core_bank    = 8'h05 + takes_q;

	// ==========================================================
	// acknowledge held one cycle, counted only with the request up
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			core_irq_ack <= 1'b0;
			wait_q       <= 4'h0;
			takes_q      <= 8'h00;
			ctx_q        <= 24'h000000;
		end
		else if (core_irq_ack)
		begin
			core_irq_ack <= 1'b0;
			if (irq_req_q)
			begin
				takes_q <= takes_q + 8'h01;
				ctx_q   <= {core_working, core_status, core_bank};
			end
		end
		else if (auto_en && irq_req_q)
		begin
			core_irq_ack <= (wait_q == ack_delay);
			wait_q       <= (wait_q == ack_delay) ? 4'h0 : wait_q + 4'h1;
		end
		else
			wait_q <= 4'h0;
	end
endmodule

// file: tb_interrupt_priority_and_sources.sv
// self-checking bench for the interrupt priority and source block
`timescale 1ns/1ps
module tb_interrupt_priority_and_sources;
	import irqc_pkg::*;
	// ==========================================================
	// signals
	logic              clk, sys_rst, reg_wr, reg_rd, timer_zero_tick, sleep_mode, core_retfie;
	logic              core_irq_ack, irq_req_q, irq_high_q, wake_q, auto_en;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata_q, periph_pend_one, periph_pend_two;
	logic [DATA_W-1:0] periph_pend_three, core_working, core_status, core_bank;
	logic [DATA_W-1:0] shadow_working_q, shadow_status_q, shadow_bank_q;
	logic [3:0]        ext_pins, port_b_upper, ack_delay;
	logic [5:0]        reset_cause_evt;
	logic [7:0]        takes_q;
	logic [PC_W-1:0]   core_pc, ret_pc_q;
	logic [VEC_W-1:0]  irq_vector_q;
	logic [PC_W-1:0]   pcs[$];
	int                fail_count, n_checks;
	// write rows carry bit 12; read rows hold the expected byte
	logic [12:0] rows [31] = '{13'h00fb, 13'h01ce, 13'h0236, 13'h033c, 13'h0400, 13'h057f,
		13'h06c0, 13'h0700, 13'h0800, 13'h0900, 13'h0f00, 13'h1000, 13'h0000, 13'h10ff,
		13'h00fb, 13'h1200, 13'h0230, 13'h12ff, 13'h0236, 13'h11ff, 13'h01ce, 13'h1100,
		13'h0100, 13'h13ff, 13'h03bf, 13'h1300, 13'h030c, 13'h1fa5, 13'h0f00, 13'h1380,
		13'h038c};

	irqc_core      i_irqc_core (.*);
	irqc_cpu_model i_irqc_cpu_model (.*);

	always #2 clk = ~clk;

	// ==========================================================
	// tasks
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic timeout();
		fail_count++;
		$display("wrong value at %0t: wait ran out", $time);
		end_of_test();
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 cmp({24'h0, reg_rdata_q & m}, {24'h0, e}, "register read");
		@(posedge clk);
	endtask
	task automatic chk_req(input logic [VEC_W-1:0] v);
		int i;
		#1;
		for (i = 0; i < 20 && irq_req_q !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		if (i == 20)
			timeout();
		cmp({15'h0, irq_high_q, irq_vector_q}, {15'h0, v == VEC_HIGH, v}, "vector");
	endtask
	task automatic quiet();
		int hits;
		hits = 0;
		repeat (8)
		begin
			@(posedge clk);
			#1;
			if (irq_req_q !== 1'b0)
				hits++;
		end
		cmp(hits, 0, "request while blocked");
	endtask
	task automatic take(input logic [3:0] dly);
		int i;
		logic [7:0] k;
		k = takes_q;
		ack_delay <= dly;
		auto_en <= 1'b1;
		for (i = 0; i < 40 && takes_q === k; i++)
		begin
			@(posedge clk);
			#1;
		end
		auto_en <= 1'b0;
		if (takes_q === k)
			timeout();
		cmp({shadow_working_q, shadow_status_q, shadow_bank_q, irq_req_q},
			{8'ha0 + k, 8'h50 + k, 8'h05 + k, 1'b0}, "take");
		cmp(i_irqc_cpu_model.ctx_q, {8'ha0 + k, 8'h50 + k, 8'h05 + k}, "software save");
		pcs.push_back(21'h000100 + {13'h0000, k});
	endtask
	task automatic ret();
		core_retfie <= 1'b1;
		@(posedge clk);
		core_retfie <= 1'b0;
		@(posedge clk);
		#1 cmp({11'h0, ret_pc_q}, {11'h0, pcs.pop_back()}, "return address");
	endtask
	task automatic tick();
		timer_zero_tick <= 1'b1;
		@(posedge clk);
		timer_zero_tick <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// ==========================================================
	// sequence
	initial
	begin
		{clk, reg_wr, reg_rd, timer_zero_tick, sleep_mode, core_retfie, auto_en} = '0;
		{reg_addr, reg_wdata, ext_pins, port_b_upper, ack_delay, reset_cause_evt} = '0;
		{periph_pend_one, periph_pend_two, periph_pend_three} = '0;
		{fail_count, n_checks} = '0;
		sys_rst = 1'b1;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i][12])
				wr(rows[i][11:8], rows[i][7:0]);
			else
				rd(rows[i][11:8], 8'hff, rows[i][7:0]);
		end
		reset_cause_evt <= 6'h3f;
		@(posedge clk);
		reset_cause_evt <= 6'h00;
		rd(OFF_RST_CAUSE, 8'hff, 8'hbf);
		// pin zero rising, always high priority
		wr(OFF_CTL_SECOND, 8'h08);
		wr(OFF_CTL_FIRST, 8'hd0);
		ext_pins <= 4'h1;
		chk_req(VEC_HIGH);
		rd(OFF_CTL_FIRST, 8'h02, 8'h02);
		take(4'h0);
		rd(OFF_CTL_FIRST, 8'hc0, 8'h40);
		wr(OFF_CTL_FIRST, 8'h50);
		ret();
		// pin one: rising ignored, falling flags; blocked until enabled
		ext_pins <= 4'h3;
		@(posedge clk);
		ext_pins <= 4'h1;
		quiet();
		rd(OFF_CTL_THIRD, 8'h3f, 8'h01);
		wr(OFF_CTL_THIRD, 8'h09);
		chk_req(VEC_LOW);
		take(4'h5);
		ext_pins <= 4'h0;
		@(posedge clk);
		ext_pins <= 4'h1;
		chk_req(VEC_HIGH);
		take(4'h2);
		wr(OFF_CTL_FIRST, 8'h10);
		wr(OFF_CTL_THIRD, 8'h08);
		ret();
		ret();
		rd(OFF_CTL_FIRST, 8'hc0, 8'hc0);
		// timer zero wraps in both widths
		wr(OFF_TMR0_LOW, 8'hff);
		tick();
		rd(OFF_CTL_FIRST, 8'h04, 8'h04);
		wr(OFF_CTL_FIRST, 8'h00);
		wr(OFF_TMR0_CFG, 8'h01);
		wr(OFF_TMR0_LOW, 8'hff);
		tick();
		rd(OFF_CTL_FIRST, 8'h04, 8'h00);
		rd(OFF_TMR0_HIGH, 8'hff, 8'h01);
		wr(OFF_TMR0_HIGH, 8'hff);
		wr(OFF_TMR0_LOW, 8'hff);
		tick();
		rd(OFF_TMR0_HIGH, 8'hff, 8'h00);
		rd(OFF_CTL_FIRST, 8'h04, 8'h04);
		wr(OFF_CTL_SECOND, 8'h0c);
		wr(OFF_CTL_FIRST, 8'he4);
		chk_req(VEC_HIGH);
		wr(OFF_CTL_FIRST, 8'h00);
		// port b change, low priority
		port_b_upper <= 4'h8;
		repeat (3) @(posedge clk);
		rd(OFF_CTL_FIRST, 8'h01, 8'h01);
		wr(OFF_CTL_FIRST, 8'hc9);
		chk_req(VEC_LOW);
		// wake without vectoring while globals are off
		wr(OFF_CTL_FIRST, 8'h10);
		ext_pins <= 4'h0;
		sleep_mode <= 1'b1;
		repeat (3) @(posedge clk);
		ext_pins <= 4'h1;
		repeat (4) @(posedge clk);
		#1 cmp({wake_q, irq_req_q}, 2'b10, "wake");
		sleep_mode <= 1'b0;
		wr(OFF_CTL_FIRST, 8'h00);
		// single level needs the peripheral enable; priority bits idle
		wr(OFF_RST_CAUSE, 8'h00);
		wr(OFF_PRIO_ONE, 8'h00);
		wr(OFF_CTL_FIRST, 8'h80);
		periph_pend_one <= 8'h01;
		quiet();
		wr(OFF_CTL_FIRST, 8'hc0);
		chk_req(VEC_HIGH);
		wr(OFF_RST_CAUSE, 8'h80);
		chk_req(VEC_LOW);
		wr(OFF_PRIO_ONE, 8'h01);
		chk_req(VEC_HIGH);
		periph_pend_one <= 8'h00;
		// ==========================================================
		// mid-run reset with pin zero and a port b pin held high
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(OFF_CTL_FIRST, 8'hff, 8'h00);
		rd(OFF_RST_CAUSE, 8'hff, 8'h3c);
		end_of_test();
	end
endmodule
